// ===== verilog/lcdd_defines.svh
`ifndef LCDD_DEFINES_SVH
`define LCDD_DEFINES_SVH

// APB register offsets
`define LCDD_OFS_CMD    8'h00
`define LCDD_OFS_DATA   8'h04
`define LCDD_OFS_STAT   8'h08
`define LCDD_OFS_CTRL   8'h0C

// Full instruction codes
`define LCDD_OP_RESET   8'hE2
`define LCDD_OP_SUB_IN  8'h70
`define LCDD_OP_SUB_OUT 8'h71

// Instruction codes without their low data bit
`define LCDD_OP_DISP    7'h57
`define LCDD_OP_INV     7'h53
`define LCDD_OP_ADC     7'h50

// Upper nibbles of the split address instructions
`define LCDD_NB_SL_HI   4'h5
`define LCDD_NB_SL_LO   4'h6
`define LCDD_NB_PG_HI   4'h4
`define LCDD_NB_PG_LO   4'hC
`define LCDD_NB_CA_HI   4'h1
`define LCDD_NB_CA_LO   4'h0

// Display RAM geometry
`define LCDD_LINES      9'h0A0
`define LCDD_PAGES      20
`define LCDD_COLS       132
`define LCDD_COL_LAST   8'h83
`define LCDD_COL_STOP   8'h84
`define LCDD_PAGE_MAX   5'h13
`define LCDD_DUTY       104

// Timing, in ns, and derived cycle counts
`define LCDD_CLK_NS     5
`define LCDD_BUSY_NS    20
`define LCDD_RESET_NS   1000
`define LCDD_BUSY_CYC  ((`LCDD_BUSY_NS + `LCDD_CLK_NS - 1) / `LCDD_CLK_NS)
`define LCDD_RESET_CYC ((`LCDD_RESET_NS + `LCDD_CLK_NS - 1) / `LCDD_CLK_NS)

`endif

// ===== verilog/lcdd_pkg.sv
package lcdd_pkg;

  // Instruction-controlled state, plus serial mode set through the CTRL register
  typedef struct packed {
    logic       disp_on;
    logic       inverse;
    logic       adc_inv;
    logic       sub_mode;
    logic       serial;
    logic [7:0] start_line;
    logic [4:0] page;
    logic [7:0] col;
  } lcdd_ctrl_t;

  // Busy, reset and read-buffer sequencing
  typedef struct packed {
    logic       busy;
    logic [7:0] busy_cnt;
    logic [7:0] rst_cnt;
    logic       rd_pend;
    logic [7:0] rd_latch;
  } lcdd_seq_t;

  // APB answer
  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } lcdd_rsp_t;

  // Panel scan pipeline
  typedef struct packed {
    logic [2:0] bit_sel;
    logic       in_range;
    logic       pixel;
  } lcdd_scan_t;

  typedef enum logic [2:0] {
    LCDD_REG_CMD  = 3'b000,
    LCDD_REG_DATA = 3'b001,
    LCDD_REG_STAT = 3'b010,
    LCDD_REG_CTRL = 3'b011,
    LCDD_REG_NONE = 3'b100
  } lcdd_reg_t;

endpackage

// ===== verilog/lcdd_ram.sv
`timescale 1ns/10ps
`include "lcdd_defines.svh"

module lcdd_ram
  import lcdd_pkg::*;
#(
  parameter int PAGES = `LCDD_PAGES,
  parameter int COLS  = `LCDD_COLS
) (
  input  logic       clk_in,
  input  logic       wr_en_in,
  input  logic [4:0] host_page_in,
  input  logic [7:0] host_col_in,
  input  logic [7:0] wr_data_in,
  output logic [7:0] host_rd_out,
  input  logic [4:0] scan_page_in,
  input  logic [7:0] scan_col_in,
  output logic [7:0] scan_rd_out
);

  localparam int DEPTH = PAGES * COLS;
  localparam int AW    = $clog2(DEPTH);

  logic [7:0] mem [DEPTH];

  // Linear address; out of range maps to DEPTH
  function automatic int addr_of(input logic [4:0] pg,
                                 input logic [7:0] cl);
    if (int'(pg) >= PAGES || int'(cl) >= COLS) begin
      return DEPTH;
    end
    return int'(pg) * COLS + int'(cl);
  endfunction

  // One write port, two synchronous read ports
  always_ff @(posedge clk_in) begin
    if (wr_en_in && addr_of(host_page_in, host_col_in) < DEPTH) begin
      mem[AW'(addr_of(host_page_in, host_col_in))] <= wr_data_in;
    end
    if (addr_of(host_page_in, host_col_in) < DEPTH) begin
      host_rd_out <= mem[AW'(addr_of(host_page_in, host_col_in))];
    end else begin
      host_rd_out <= 8'h00;
    end
    if (addr_of(scan_page_in, scan_col_in) < DEPTH) begin
      scan_rd_out <= mem[AW'(addr_of(scan_page_in, scan_col_in))];
    end else begin
      scan_rd_out <= 8'h00;
    end
  end

endmodule

// ===== verilog/lcdd_top.sv
// The APB register port and the address map were decided locally.
`timescale 1ns/10ps
`include "lcdd_defines.svh"

// Behaviour
// - On/off bit D0 lights or blanks panel
// - Two writes set start line, maps first common
// - Duty lines shown upward from start line
// - Two writes set page, pages 0 to 19
// - Page change never alters panel image
// - Two writes set column, 0 to 83 hex
// - Column advances after each data access
// - Column stops at last plus one, page kept
// - Status byte: busy, direction, on/off, reset
// - Busy while operating; host waits for zero
// - Direction status reads one for normal
// - On/off status reads zero when on
// - Reset status one during initialisation
// - Data write stores byte, advances column
// - Data read returns byte, advances column
// - First read after column set is dummy
// - No display data reads in serial mode
// - Inverse flips polarity, RAM untouched
// - Inverse bit zero normal, one inverse
module lcdd_top
  import lcdd_pkg::*;
#(
  parameter int DUTY      = `LCDD_DUTY,
  parameter int RESET_CYC = `LCDD_RESET_CYC
) (
  input  logic        clk_in,
  input  logic        arst_n_in,
  input  logic        psel_in,
  input  logic        penable_in,
  input  logic        pwrite_in,
  input  logic [7:0]  paddr_in,
  input  logic [31:0] pwdata_in,
  output logic        pready_out,
  output logic [31:0] prdata_out,
  output logic        pslverr_out,
  input  logic [6:0]  scan_com_in,
  input  logic [7:0]  scan_col_in,
  output logic        scan_pixel_out,
  output logic        busy_out
);

  lcdd_ctrl_t ctrl;
  lcdd_ctrl_t next_ctrl;
  lcdd_seq_t  seq;
  lcdd_seq_t  next_seq;
  lcdd_rsp_t  rsp;
  lcdd_rsp_t  next_rsp;
  lcdd_scan_t scan;
  lcdd_scan_t next_scan;

  lcdd_reg_t  sel;
  logic [7:0] op;
  logic       acc_ok;
  logic       cmd_go;
  logic       dat_wr_go;
  logic       dat_rd_go;
  logic       ram_we;
  logic [7:0] host_rd;
  logic [7:0] scan_rd;
  logic [7:0] status_byte;
  logic [8:0] scan_line;
  logic [7:0] scan_col;

  // Map an APB offset to a register
  function automatic lcdd_reg_t reg_of(input logic [7:0] a);
    case (a)
      `LCDD_OFS_CMD:  return LCDD_REG_CMD;
      `LCDD_OFS_DATA: return LCDD_REG_DATA;
      `LCDD_OFS_STAT: return LCDD_REG_STAT;
      `LCDD_OFS_CTRL: return LCDD_REG_CTRL;
      default:        return LCDD_REG_NONE;
    endcase
  endfunction

  // RAM line for a common, wrapped at the line count
  function automatic logic [8:0] line_of(input logic [7:0] start,
                                         input logic [6:0] com);
    logic [8:0] sum;
    sum = {1'b0, start} + {2'b00, com};
    if (sum >= `LCDD_LINES) begin
      sum = sum - `LCDD_LINES;
    end
    if (sum >= `LCDD_LINES) begin
      sum = sum - `LCDD_LINES;
    end
    return sum;
  endfunction

  // Completed APB accesses and what they start
  assign sel    = reg_of(paddr_in);
  assign op     = pwdata_in[7:0];
  assign acc_ok = psel_in && penable_in && rsp.pready && !rsp.pslverr;
  assign cmd_go = acc_ok && pwrite_in && sel == LCDD_REG_CMD
                  && !seq.busy;
  assign dat_wr_go = acc_ok && pwrite_in && sel == LCDD_REG_DATA
                     && !seq.busy;
  assign dat_rd_go = acc_ok && !pwrite_in && sel == LCDD_REG_DATA
                     && !seq.busy && !ctrl.serial;
  assign ram_we = dat_wr_go && ctrl.page <= `LCDD_PAGE_MAX
                  && ctrl.col <= `LCDD_COL_LAST;

  // Status byte, reserved low nibble zero
  assign status_byte = {seq.busy, !ctrl.adc_inv, !ctrl.disp_on,
                        seq.rst_cnt != 8'h00, 4'h0};

  // Scan address, segment order per direction select
  assign scan_line = line_of(ctrl.start_line, scan_com_in);
  assign scan_col  = ctrl.adc_inv ? (`LCDD_COL_LAST - scan_col_in)
                                  : scan_col_in;

  lcdd_ram #(
    .PAGES (`LCDD_PAGES),
    .COLS  (`LCDD_COLS)
  ) u_ram (
    .clk_in       (clk_in),
    .wr_en_in     (ram_we),
    .host_page_in (ctrl.page),
    .host_col_in  (ctrl.col),
    .wr_data_in   (op),
    .host_rd_out  (host_rd),
    .scan_page_in (scan_line[7:3]),
    .scan_col_in  (scan_col),
    .scan_rd_out  (scan_rd)
  );

  // Instruction decode, column advance, busy and reset timing
  always_comb begin
    next_ctrl = ctrl;
    next_seq  = seq;
    next_seq.rd_pend = 1'b0;
    if (seq.busy_cnt != 8'h00) begin
      next_seq.busy_cnt = seq.busy_cnt - 8'h01;
    end
    if (seq.rst_cnt != 8'h00) begin
      next_seq.rst_cnt = seq.rst_cnt - 8'h01;
    end
    if (seq.rd_pend) begin
      next_seq.rd_latch = host_rd;
    end
    if (acc_ok && pwrite_in && sel == LCDD_REG_CTRL) begin
      next_ctrl.serial = pwdata_in[0];
    end
    if (cmd_go) begin
      next_seq.busy_cnt = 8'(`LCDD_BUSY_CYC);
      if (ctrl.sub_mode) begin
        if (op == `LCDD_OP_SUB_OUT) begin
          next_ctrl.sub_mode = 1'b0;
        end
      end else if (op == `LCDD_OP_SUB_IN) begin
        next_ctrl.sub_mode = 1'b1;
      end else if (op == `LCDD_OP_RESET) begin
        next_ctrl        = '0;
        next_ctrl.serial = ctrl.serial;
        next_seq.rst_cnt = 8'(RESET_CYC);
      end else if (op[7:1] == `LCDD_OP_DISP) begin
        next_ctrl.disp_on = op[0];
      end else if (op[7:1] == `LCDD_OP_INV) begin
        next_ctrl.inverse = op[0];
      end else if (op[7:1] == `LCDD_OP_ADC) begin
        next_ctrl.adc_inv = op[0];
      end else begin
        case (op[7:4])
          `LCDD_NB_SL_HI: next_ctrl.start_line[7:4] = op[3:0];
          `LCDD_NB_SL_LO: next_ctrl.start_line[3:0] = op[3:0];
          `LCDD_NB_PG_HI: next_ctrl.page[4]         = op[0];
          `LCDD_NB_PG_LO: next_ctrl.page[3:0]       = op[3:0];
          `LCDD_NB_CA_HI: next_ctrl.col[7:4]        = op[3:0];
          `LCDD_NB_CA_LO: next_ctrl.col[3:0]        = op[3:0];
          default: ;
        endcase
      end
    end
    // Read buffer is not refilled by address set: stale dummy read
    if (dat_wr_go || dat_rd_go) begin
      next_seq.busy_cnt = 8'(`LCDD_BUSY_CYC);
      if (ctrl.col < `LCDD_COL_STOP) begin
        next_ctrl.col = ctrl.col + 8'h01;
      end
    end
    if (dat_rd_go) begin
      next_seq.rd_pend = 1'b1;
    end
    next_seq.busy = next_seq.busy_cnt != 8'h00
                    || next_seq.rst_cnt != 8'h00;
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      ctrl             <= '0;
      seq              <= '0;
      seq.busy         <= 1'b1;
      seq.rst_cnt      <= 8'(RESET_CYC);
    end else begin
      ctrl <= next_ctrl;
      seq  <= next_seq;
    end
  end

  // APB answer, ready in the first access cycle
  always_comb begin
    next_rsp = '0;
    if (psel_in && !penable_in) begin
      next_rsp.pready = 1'b1;
      case (sel)
        LCDD_REG_CMD: begin
          next_rsp.pslverr = !pwrite_in;
        end
        LCDD_REG_DATA: begin
          if (!ctrl.serial) begin
            next_rsp.prdata = {24'h00_0000, seq.rd_latch};
          end
        end
        LCDD_REG_STAT: begin
          next_rsp.prdata  = {24'h00_0000, status_byte};
          next_rsp.pslverr = pwrite_in;
        end
        LCDD_REG_CTRL: begin
          next_rsp.prdata = {31'h0000_0000, ctrl.serial};
        end
        default: begin
          next_rsp.pslverr = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rsp <= '0;
    end else begin
      rsp <= next_rsp;
    end
  end

  // Panel pixel: blanking and polarity, RAM left as is
  always_comb begin
    next_scan          = scan;
    next_scan.bit_sel  = scan_line[2:0];
    next_scan.in_range = scan_col_in <= `LCDD_COL_LAST
                         && int'(scan_com_in) < DUTY;
    next_scan.pixel    = ctrl.disp_on && scan.in_range
                         && (scan_rd[scan.bit_sel]
                             ^ ctrl.inverse);
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      scan <= '0;
    end else begin
      scan <= next_scan;
    end
  end

  // Outputs straight from flops
  assign pready_out     = rsp.pready;
  assign prdata_out     = rsp.prdata;
  assign pslverr_out    = rsp.pslverr;
  assign scan_pixel_out = scan.pixel;
  assign busy_out       = seq.busy;

  // Checks
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);

  AST_DISP_ON: assert property (
    cmd_go && !ctrl.sub_mode && op[7:1] == `LCDD_OP_DISP
    |=> ctrl.disp_on == $past(op[0]))
    else $error("display on/off not taken");

  AST_DARK: assert property (
    !ctrl.disp_on |=> !scan_pixel_out)
    else $error("pixel lit while display off");

  AST_START_HI: assert property (
    cmd_go && !ctrl.sub_mode && op[7:4] == `LCDD_NB_SL_HI
    |=> ctrl.start_line[7:4] == $past(op[3:0])
        && $stable(ctrl.start_line[3:0]))
    else $error("start line high nibble wrong");

  AST_SCAN_LINE: assert property (
    scan_line < `LCDD_LINES)
    else $error("scan line out of range");

  AST_PAGE_HOLD: assert property (
    cmd_go && !ctrl.sub_mode && op[7:4] == `LCDD_NB_PG_LO
    |=> $stable(ctrl.start_line) && $stable(ctrl.disp_on)
        && ctrl.page[3:0] == $past(op[3:0]))
    else $error("page set disturbed display");

  AST_COL_INC: assert property (
    (dat_wr_go || dat_rd_go) && ctrl.col < `LCDD_COL_STOP
    |=> ctrl.col == $past(ctrl.col) + 8'h01)
    else $error("column did not advance");

  AST_COL_STOP: assert property (
    (dat_wr_go || dat_rd_go) && ctrl.col == `LCDD_COL_STOP
    |=> ctrl.col == `LCDD_COL_STOP && $stable(ctrl.page))
    else $error("column passed stop");

  AST_STATUS: assert property (
    psel_in && !penable_in && sel == LCDD_REG_STAT && !pwrite_in
    |=> prdata_out[3:0] == 4'h0
        && prdata_out[6] == !$past(ctrl.adc_inv)
        && prdata_out[5] == !$past(ctrl.disp_on)
        && prdata_out[7] == $past(seq.busy))
    else $error("status byte wrong");

  AST_BUSY: assert property (
    dat_wr_go |=> busy_out [*4])
    else $error("busy not held for operation");

  AST_RESET_FLAG: assert property (
    cmd_go && !ctrl.sub_mode && op == `LCDD_OP_RESET
    |=> status_byte[4] && status_byte[7] && !ctrl.disp_on)
    else $error("reset status not shown");

  AST_DUMMY: assert property (
    cmd_go && op[7:4] == `LCDD_NB_CA_LO && !seq.rd_pend
    |=> $stable(seq.rd_latch))
    else $error("read buffer refilled by column set");

  AST_SERIAL: assert property (
    acc_ok && !pwrite_in && sel == LCDD_REG_DATA && ctrl.serial
    |=> $stable(ctrl.col) && !seq.rd_pend)
    else $error("serial mode data read acted");

  AST_INVERSE: assert property (
    cmd_go && !ctrl.sub_mode && op[7:1] == `LCDD_OP_INV
    |=> ctrl.inverse == $past(op[0]) && !ram_we)
    else $error("inverse not taken");

endmodule

// ===== bench/lcdd_host.sv
`timescale 1ns/10ps

// Host side of the register bus: APB master with busy polling
module lcdd_host (
  input  logic        clk_in,
  input  logic        pready_in,
  input  logic [31:0] prdata_in,
  input  logic        pslverr_in,
  output logic        psel_out,
  output logic        penable_out,
  output logic        pwrite_out,
  output logic [7:0]  paddr_out,
  output logic [31:0] pwdata_out,
  output logic        hung_out
);
  logic last_err;

  // Idle bus at time zero
  initial begin
    psel_out    = 1'b0;
    penable_out = 1'b0;
    pwrite_out  = 1'b0;
    paddr_out   = 8'h00;
    pwdata_out  = 32'h0000_0000;
    hung_out    = 1'b0;
    last_err    = 1'b0;
  end

  // One transfer, request held until pready is sampled high
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] rd);
    int n;
    @(posedge clk_in);
    psel_out    <= 1'b1;
    penable_out <= 1'b0;
    pwrite_out  <= w;
    paddr_out   <= a;
    pwdata_out  <= d;
    @(posedge clk_in);
    penable_out <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_in);
      n++;
    end while (pready_in !== 1'b1 && n < 64);
    if (n >= 64) hung_out <= 1'b1;
    rd = prdata_in;
    last_err = pslverr_in;
    psel_out    <= 1'b0;
    penable_out <= 1'b0;
    pwdata_out  <= ~d; // Released data no longer valid
  endtask

  // Wait for busy low before an instruction or data access
  task automatic idle();
    logic [31:0] s;
    int n;
    n = 0;
    do begin
      rstat(s);
      n++;
    end while (s[7] !== 1'b0 && n < 400);
    if (n >= 400) hung_out <= 1'b1;
  endtask

  // Instruction write, select low
  task automatic cmd(input logic [7:0] b);
    idle();
    wcmd(b);
  endtask

  // Instruction write with no busy poll in front
  task automatic wcmd(input logic [7:0] b);
    logic [31:0] r;
    xfer(1'b1, 8'h00, {24'h00_0000, b}, r);
  endtask

  // Status read
  task automatic rstat(output logic [31:0] s);
    xfer(1'b0, 8'h08, 32'h0000_0000, s);
  endtask

  // Read of any offset
  task automatic rreg(input logic [7:0] a, output logic [31:0] s);
    xfer(1'b0, a, 32'h0000_0000, s);
  endtask

  // Interface mode write, bit 0 selects serial
  task automatic wctrl(input logic b);
    logic [31:0] r;
    xfer(1'b1, 8'h0C, {31'h0000_0000, b}, r);
  endtask

  // Display data write, select high
  task automatic wdat(input logic [7:0] b);
    logic [31:0] r;
    idle();
    xfer(1'b1, 8'h04, {24'h00_0000, b}, r);
  endtask

  // Display data read
  task automatic rdat(output logic [7:0] b);
    logic [31:0] r;
    idle();
    xfer(1'b0, 8'h04, 32'h0000_0000, r);
    b = r[7:0];
  endtask

  // Split address writes, high part first
  task automatic setcol(input logic [7:0] c);
    cmd({4'h1, c[7:4]});
    cmd({4'h0, c[3:0]});
  endtask

  task automatic setpg(input logic [4:0] p);
    cmd({7'h20, p[4]});
    cmd({4'hC, p[3:0]});
  endtask

  task automatic setsl(input logic [7:0] l);
    cmd({4'h5, l[7:4]});
    cmd({4'h6, l[3:0]});
  endtask
endmodule

// ===== bench/tb.sv
`timescale 1ns/10ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin err_total++; \
  $display("[ERR] %0t got %0h exp %0h", $time, g, e); end end

module tb;
  import lcdd_pkg::*;
  logic        clk_in;
  logic        arst_n_in;
  logic        psel, penable, pwrite, pready, pslverr, hung;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, r;
  logic [6:0]  scan_com_in;
  logic [7:0]  scan_col_in, d;
  logic        scan_pixel_out, busy_out;
  int          err_total, n_tests;
  logic [7:0]  row_op [4] = '{8'hAF, 8'hA1, 8'hA0, 8'hAE};
  logic [31:0] row_st [4] = '{32'h0000_0040, 32'h0000_0000,
                              32'h0000_0040, 32'h0000_0060};

  lcdd_top #(.RESET_CYC(8)) u_lcdd_top (
    .clk_in(clk_in), .arst_n_in(arst_n_in), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
    .pwdata_in(pwdata), .pready_out(pready), .prdata_out(prdata),
    .pslverr_out(pslverr), .scan_com_in(scan_com_in),
    .scan_col_in(scan_col_in), .scan_pixel_out(scan_pixel_out),
    .busy_out(busy_out));

  lcdd_host u_lcdd_host (
    .clk_in(clk_in), .pready_in(pready), .prdata_in(prdata),
    .pslverr_in(pslverr), .psel_out(psel), .penable_out(penable),
    .pwrite_out(pwrite), .paddr_out(paddr), .pwdata_out(pwdata),
    .hung_out(hung));

  // Clock, 5 ns period
  initial clk_in = 1'b0;
  always #2.5 clk_in = ~clk_in;

  task automatic wrap_up();
    $display("Checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Panel pixel two edges after the scan position
  task automatic scan_chk(input logic [6:0] c, input logic [7:0] s,
                          input logic e);
    scan_com_in <= c;
    scan_col_in <= s;
    repeat (3) @(posedge clk_in);
    `CHK(scan_pixel_out, e)
  endtask

  // A bus wait that ran out ends the run
  always @(posedge hung) begin
    err_total++;
    wrap_up();
  end

  initial begin
    arst_n_in   = 1'b0;
    scan_com_in = 7'h00;
    scan_col_in = 8'h00;
    repeat (8) @(posedge clk_in);
    `CHK(busy_out, 1'b1)
    arst_n_in <= 1'b1;
    u_lcdd_host.rstat(r);
    `CHK(r, 32'h0000_00F0)
    u_lcdd_host.idle();
    // Table of instructions and the status they leave
    for (int i = 0; i < 4; i++) begin
      u_lcdd_host.cmd(row_op[i]);
      u_lcdd_host.idle();
      u_lcdd_host.rstat(r);
      `CHK(r, row_st[i])
    end
    // Writes run past the last column, which then holds
    u_lcdd_host.setpg(5'h13);
    u_lcdd_host.setcol(8'h00);
    u_lcdd_host.wdat(8'hC3);
    u_lcdd_host.setcol(8'h82);
    u_lcdd_host.wdat(8'hA5);
    u_lcdd_host.wdat(8'h5A);
    u_lcdd_host.wdat(8'h33);
    u_lcdd_host.setcol(8'h82);
    u_lcdd_host.rdat(d);
    u_lcdd_host.rdat(d);
    `CHK(d, 8'hA5)
    u_lcdd_host.rdat(d);
    `CHK(d, 8'h5A)
    u_lcdd_host.setcol(8'h00);
    u_lcdd_host.rdat(d);
    u_lcdd_host.rdat(d);
    `CHK(d, 8'hC3)
    // Scrolled panel, inverse and page change
    u_lcdd_host.cmd(8'hAF);
    u_lcdd_host.setsl(8'h98);
    scan_chk(7'h00, 8'h82, 1'b1);
    scan_chk(7'h01, 8'h82, 1'b0);
    u_lcdd_host.cmd(8'hA7);
    scan_chk(7'h01, 8'h82, 1'b1);
    u_lcdd_host.setpg(5'h00);
    scan_chk(7'h01, 8'h82, 1'b1);
    scan_chk(7'h68, 8'h82, 1'b0);
    u_lcdd_host.cmd(8'hA6);
    scan_chk(7'h00, 8'h82, 1'b1);
    // Mirrored segment order reads column 131 minus col
    u_lcdd_host.cmd(8'hA1);
    scan_chk(7'h00, 8'h01, 1'b1);
    u_lcdd_host.cmd(8'hA0);
    u_lcdd_host.cmd(8'hAE);
    scan_chk(7'h00, 8'h82, 1'b0);
    // Refused accesses
    u_lcdd_host.rreg(8'h10, r);
    `CHK(u_lcdd_host.last_err, 1'b1)
    u_lcdd_host.rreg(8'h00, r);
    `CHK(u_lcdd_host.last_err, 1'b1)
    // Serial mode blocks display reads
    u_lcdd_host.wctrl(1'b1);
    u_lcdd_host.setpg(5'h13);
    u_lcdd_host.setcol(8'h82);
    u_lcdd_host.rdat(d);
    u_lcdd_host.rdat(d);
    `CHK(d, 8'h00)
    u_lcdd_host.wctrl(1'b0);
    // Sub-table mode swallows main instructions until its end code
    u_lcdd_host.cmd(8'h70);
    u_lcdd_host.cmd(8'hAF);
    u_lcdd_host.cmd(8'h71);
    u_lcdd_host.idle();
    u_lcdd_host.rstat(r);
    `CHK(r, 32'h0000_0060)
    // Reset instruction; an instruction sent while busy is dropped
    u_lcdd_host.cmd(8'hE2);
    u_lcdd_host.rstat(r);
    `CHK(r[4], 1'b1)
    u_lcdd_host.wcmd(8'hAF);
    u_lcdd_host.idle();
    u_lcdd_host.rstat(r);
    `CHK(r, 32'h0000_0060)
    // Reset pin pulsed in mid-run
    arst_n_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    `CHK(busy_out, 1'b1)
    arst_n_in <= 1'b1;
    u_lcdd_host.rstat(r);
    `CHK(r, 32'h0000_00F0)
    wrap_up();
  end
endmodule
